// ==== hw/cmd_decode_pkg.sv ====
// Package for the DRAM command decoder: pin groups, command codes, counts.
// Assumes a single 200 MHz clock domain and a synchronous active-high reset.
package cmd_decode_pkg;

    // -------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------
    localparam int BANK_W = 3;
    localparam int ADDR_W = 16;
    localparam int NBANKS = 8;

    // -------------------------------------------------------------------
    // Address bit positions
    // -------------------------------------------------------------------
    localparam int AUTO_PRECHARGE_POS = 10;
    localparam int BURST_CHOP_POS = 12;

    // -------------------------------------------------------------------
    // Burst timing: beats at two per clock
    // -------------------------------------------------------------------
    localparam logic [2:0] BURST8_CYCLES = 3'h4;
    localparam logic [2:0] BURST4_CYCLES = 3'h2;
    localparam logic [2:0] ZERO3 = 3'h0;

    // -------------------------------------------------------------------
    // Geometry defaults after reset (row and column width in bits)
    // -------------------------------------------------------------------
    localparam logic [4:0] ROW_BITS_RESET = 5'h10;
    localparam logic [3:0] COL_BITS_RESET = 4'hA;

    // Pin group sampled at each rising edge, control pins active low except clock enable
    typedef struct packed {
        logic cke;
        logic chip_select_n;
        logic row_strobe_n;
        logic col_strobe_n;
        logic write_enable_n;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] addr;
    } cmd_pins_t;

    // Decoded command
    typedef enum logic [4:0] {
        CMD_DESELECT,
        CMD_NO_OPERATION,
        CMD_MODE_REGISTER_WRITE,
        CMD_REFRESH,
        CMD_SELF_REFRESH_ENTRY,
        CMD_SELF_REFRESH_EXIT,
        CMD_BANK_CLOSE,
        CMD_ALL_BANK_CLOSE,
        CMD_ROW_OPEN,
        CMD_READ,
        CMD_WRITE,
        CMD_IMPEDANCE_CAL_LONG,
        CMD_IMPEDANCE_CAL_SHORT,
        CMD_POWERDOWN_ENTRY,
        CMD_POWERDOWN_EXIT,
        CMD_ILLEGAL
    } cmd_code_t;

    // Strobe group handed to the core, one cycle per command
    typedef struct packed {
        logic valid;
        cmd_code_t code;
        logic [BANK_W-1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic chop4;
        logic auto_close;
        logic [1:0] mode_reg_sel;
        logic [ADDR_W-1:0] mode_data;
    } cmd_out_t;

endpackage

// ==== hw/pin_capture.sv ====
// Registers the command pins at each rising edge and the previous clock enable.
// Assumes the pins are already timed to ref_clk by the input stage.
`timescale 1ns/1ps
module pin_capture (
    input wire logic ref_clk,
    input wire logic rst,
    input wire cmd_decode_pkg::cmd_pins_t pins,
    output cmd_decode_pkg::cmd_pins_t pins_reg,
    output logic cke_prev_reg
);
    import cmd_decode_pkg::*;

    typedef struct packed {
        cmd_pins_t pins;
        logic cke_prev;
    } cap_state_t;

    cap_state_t state_reg;
    cap_state_t state_next;

    // Shift current sample into place and remember last clock enable
    // previous level kept
    always_comb
    begin
        state_next = state_reg;
        state_next.cke_prev = state_reg.pins.cke;
        state_next.pins = pins;
    end

    // Reset holds a deselect with clock enable low
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.pins.chip_select_n <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign pins_reg = state_reg.pins;
    assign cke_prev_reg = state_reg.cke_prev;

    // Clock enable pair tracks one edge apart
    chk_cke_pair: assert property (@(posedge ref_clk) disable iff (rst)
        !$past(rst) |-> cke_prev_reg == $past(pins_reg.cke))
        else $error("previous clock enable not tracked");
endmodule

// ==== hw/burst_timer.sv ====
// One burst counter: loads on start and runs to zero, never cut short.
// Assumes start is a single-cycle strobe from the decoder.
`timescale 1ns/1ps
module burst_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [2:0] length,
    output logic busy
);
    import cmd_decode_pkg::*;

    typedef struct packed {
        logic [2:0] count;
    } timer_state_t;

    timer_state_t state_reg;
    timer_state_t state_next;

    // Load when idle, count down otherwise
    always_comb
    begin
        state_next = state_reg;
        if (state_reg.count != ZERO3)
        begin
            state_next.count = state_reg.count - 3'h1;
        end
        else if (start)
        begin
            state_next.count = length;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign busy = state_reg.count != ZERO3;

    chk_burst_full: assert property (@(posedge ref_clk) disable iff (rst)
        (busy && state_reg.count > 3'h1) |=> busy)
        else $error("burst stopped early");
endmodule

// ==== hw/cmd_decoder.sv ====
// Command decoder of a DDR DRAM: samples control pins, decodes commands,
// tracks bank, burst, power-down and self-refresh state.
// Assumes the controller drives valid levels and holds the reset pin high.
//
// How it works
// - Commands decode from select, strobes, write enable, clock enable, address bit 10 and power state.
// - Bank pins pick the bank, or the mode register being written.
// - Upper row and column bits beyond configured geometry are ignored.
// - A started burst always runs to its full length.
// - Fixed or per-command burst length comes from the mode setting.
// - Decoding ignores termination control; termination off in self refresh.
// - No refresh runs while in power-down.
// - No-operation starts nothing and lets operations continue.
// - Deselect has the same effect as no-operation but is reported as CMD_DESELECT.
// - Power-down exit leaves any running burst alone.
// - Per-command mode: chop bit low gives 4 beats, high 8; close bit precharges.
// - Fixed mode ignores chop bit; close bit chooses row open or precharge.
// - Clock enable judged as current level paired with previous level.
// - Select low, strobes and write enable high, with clock enable high in both samples, decodes no-operation.
// - Select high executes no new command unless clock enable changes (power-down entry, exit from either state).
`timescale 1ns/1ps
module cmd_decoder (
    input wire logic ref_clk,
    input wire logic rst,
    input wire cmd_decode_pkg::cmd_pins_t pins,
    input wire logic termination_control,
    input wire logic burst_on_the_fly,
    input wire logic fixed_chop4,
    input wire logic [4:0] row_bits,
    input wire logic [3:0] col_bits,
    output cmd_decode_pkg::cmd_out_t cmd,
    output logic [cmd_decode_pkg::NBANKS-1:0] bank_open,
    output logic read_busy,
    output logic write_busy,
    output logic in_powerdown,
    output logic in_self_refresh,
    output logic termination_enable,
    output logic refresh_pulse
);
    import cmd_decode_pkg::*;

    // -------------------------------------------------------------------
    // Pin sampling
    // -------------------------------------------------------------------
    cmd_pins_t p;
    logic cke_prev;
    logic rd_start;
    logic wr_start;
    logic [2:0] burst_len;

    pin_capture u_cap (
        .ref_clk(ref_clk),
        .rst(rst),
        .pins(pins),
        .pins_reg(p),
        .cke_prev_reg(cke_prev)
    );

    burst_timer u_rd (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(rd_start),
        .length(burst_len),
        .busy(read_busy)
    );

    burst_timer u_wr (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(wr_start),
        .length(burst_len),
        .busy(write_busy)
    );

    typedef enum logic [1:0] {
        PS_ACTIVE,
        PS_POWERDOWN,
        PS_SELF_REFRESH
    } pstate_t;

    typedef struct packed {
        pstate_t ps;
        logic [NBANKS-1:0] open;
        cmd_out_t out;
        logic refresh;
    } dec_state_t;

    dec_state_t state_reg;
    dec_state_t state_next;
    cmd_code_t code;
    logic [ADDR_W-1:0] row_mask;
    logic [ADDR_W-1:0] col_mask;
    logic sel_low_cmd;
    logic close_bit;
    logic idle_cmd;

    // -------------------------------------------------------------------
    // Command decode
    // -------------------------------------------------------------------
    assign close_bit = p.addr[AUTO_PRECHARGE_POS];
    assign sel_low_cmd = !p.chip_select_n;
    assign idle_cmd = p.chip_select_n
        || (!p.row_strobe_n == 1'b0 && p.col_strobe_n && p.write_enable_n);

    // decode from pin levels and power state; termination input plays no part
    always_comb
    begin
        code = CMD_ILLEGAL;
        if (cke_prev && !p.cke)
        begin
            // falling enable with refresh enters self refresh
            if (sel_low_cmd && !p.row_strobe_n && !p.col_strobe_n && p.write_enable_n)
            begin
                code = CMD_SELF_REFRESH_ENTRY;
            end
            // falling enable with idle command enters power-down
            else if (idle_cmd)
            begin
                code = CMD_POWERDOWN_ENTRY;
            end
        end
        else if (!cke_prev && p.cke)
        begin
            // rising enable leaves power-down or self refresh
            if (state_reg.ps == PS_SELF_REFRESH)
            begin
                code = CMD_SELF_REFRESH_EXIT;
            end
            else
            begin
                code = CMD_POWERDOWN_EXIT;
            end
        end
        else if (!cke_prev)
        begin
            code = CMD_DESELECT;
        end
        else if (p.chip_select_n)
        begin
            code = CMD_DESELECT;
        end
        else
        begin
            case ({p.row_strobe_n, p.col_strobe_n, p.write_enable_n})
                3'h0: code = CMD_MODE_REGISTER_WRITE; // all low
                3'h1: code = CMD_REFRESH;
                // close bit selects one or all banks
                3'h2: code = close_bit ? CMD_ALL_BANK_CLOSE : CMD_BANK_CLOSE;
                3'h3: code = CMD_ROW_OPEN;
                3'h4: code = CMD_WRITE;
                3'h5: code = CMD_READ;
                // close bit picks long or short calibration
                3'h6: code = close_bit ? CMD_IMPEDANCE_CAL_LONG : CMD_IMPEDANCE_CAL_SHORT;
                3'h7: code = CMD_NO_OPERATION;
                default: code = CMD_ILLEGAL;
            endcase
        end
    end

    // mask upper address bits beyond geometry
    assign row_mask = ADDR_W'((32'h1 << row_bits) - 32'h1);
    assign col_mask = ADDR_W'((32'h1 << col_bits) - 32'h1);

    // burst length source from mode setting
    always_comb
    begin
        if (burst_on_the_fly)
        begin
            // chop bit low gives four beats
            burst_len = p.addr[BURST_CHOP_POS] ? BURST8_CYCLES : BURST4_CYCLES;
        end
        else
        begin
            burst_len = fixed_chop4 ? BURST4_CYCLES : BURST8_CYCLES;
        end
    end

    // no new burst while one runs
    assign rd_start = code == CMD_READ && !read_busy && !write_busy;
    assign wr_start = code == CMD_WRITE && !read_busy && !write_busy;

    // -------------------------------------------------------------------
    // State update
    // -------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        state_next.out = '0;
        state_next.refresh = 1'b0;
        case (code)
            CMD_DESELECT, CMD_NO_OPERATION:
            begin
                state_next.out.code = code;
            end
            CMD_MODE_REGISTER_WRITE:
            begin
                state_next.out.mode_reg_sel = p.bank[1:0];
                state_next.out.mode_data = p.addr;
            end
            CMD_REFRESH:
            begin
                state_next.refresh = state_reg.ps == PS_ACTIVE;
            end
            CMD_SELF_REFRESH_ENTRY:
            begin
                state_next.ps = PS_SELF_REFRESH;
            end
            CMD_SELF_REFRESH_EXIT, CMD_POWERDOWN_EXIT:
            begin
                state_next.ps = PS_ACTIVE;
            end
            CMD_POWERDOWN_ENTRY:
            begin
                state_next.ps = PS_POWERDOWN;
            end
            CMD_BANK_CLOSE:
            begin
                state_next.open[p.bank] = 1'b0;
            end
            CMD_ALL_BANK_CLOSE:
            begin
                state_next.open = '0;
            end
            CMD_ROW_OPEN:
            begin
                state_next.open[p.bank] = 1'b1;
                state_next.out.row = p.addr & row_mask;
            end
            CMD_READ, CMD_WRITE:
            begin
                state_next.out.col = p.addr & col_mask;
                state_next.out.chop4 = burst_len == BURST4_CYCLES;
                state_next.out.auto_close = close_bit;
                if (close_bit)
                begin
                    state_next.open[p.bank] = 1'b0;
                end
            end
            default:
            begin
                state_next.out.code = CMD_ILLEGAL;
            end
        endcase
        if (code != CMD_DESELECT && code != CMD_NO_OPERATION)
        begin
            state_next.out.valid = code != CMD_ILLEGAL;
            state_next.out.code = code;
            state_next.out.bank = p.bank;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    assign cmd = state_reg.out;
    assign bank_open = state_reg.open;
    assign in_powerdown = state_reg.ps == PS_POWERDOWN;
    assign in_self_refresh = state_reg.ps == PS_SELF_REFRESH;
    assign refresh_pulse = state_reg.refresh;
    assign termination_enable = termination_control && state_reg.ps != PS_SELF_REFRESH;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    sequence s_self_refresh_in;
        p.cke == 1'b0 && cke_prev && !p.chip_select_n && !p.row_strobe_n
            && !p.col_strobe_n && p.write_enable_n;
    endsequence

    chk_select_high_idle: assert property (@(posedge ref_clk) disable iff (rst)
        (cke_prev && p.cke && p.chip_select_n) |=> !cmd.valid)
        else $error("command taken with select high");
    chk_idle_no_effect: assert property (@(posedge ref_clk) disable iff (rst)
        (code == CMD_NO_OPERATION) |=> !cmd.valid && $stable(bank_open))
        else $error("no-operation had an effect");
    chk_sr_entry: assert property (@(posedge ref_clk) disable iff (rst)
        s_self_refresh_in |=> in_self_refresh)
        else $error("self refresh not entered");
    chk_pd_no_refresh: assert property (@(posedge ref_clk) disable iff (rst)
        in_powerdown |=> !refresh_pulse)
        else $error("refresh during power-down");
    chk_term_off_sr: assert property (@(posedge ref_clk) disable iff (rst)
        in_self_refresh |-> !termination_enable)
        else $error("termination on in self refresh");
    chk_close_all: assert property (@(posedge ref_clk) disable iff (rst)
        (code == CMD_ALL_BANK_CLOSE) |=> bank_open == '0 && cmd.code == CMD_ALL_BANK_CLOSE)
        else $error("all-bank close left a bank open");
    chk_cal_select: assert property (@(posedge ref_clk) disable iff (rst)
        (cke_prev && p.cke && !p.chip_select_n && p.row_strobe_n && p.col_strobe_n
            && !p.write_enable_n && close_bit) |=> cmd.code == CMD_IMPEDANCE_CAL_LONG)
        else $error("long calibration not chosen with close bit high");
    chk_pd_exit_burst: assert property (@(posedge ref_clk) disable iff (rst)
        (code == CMD_POWERDOWN_EXIT && read_busy && u_rd.state_reg.count > 3'h1)
            |=> read_busy)
        else $error("power-down exit cut a burst");
    chk_fly_chop: assert property (@(posedge ref_clk) disable iff (rst)
        (rd_start && burst_on_the_fly && !p.addr[BURST_CHOP_POS]) |=> cmd.chop4 ##1 read_busy)
        else $error("chop bit low did not give four beats");
    chk_fixed_len: assert property (@(posedge ref_clk) disable iff (rst)
        ((rd_start || wr_start) && !burst_on_the_fly && !fixed_chop4) |=> !cmd.chop4)
        else $error("fixed mode used chop bit");
endmodule

// ==== dv/dram_ctrl_model.sv ====
// Controller model: drives the decoder's command pins, one command at a time.
// Assumes ref_clk is the decoder's clock; pins change 1 ns after a rising edge.
`timescale 1ns/1ps
module dram_ctrl_model (
    input wire logic ref_clk,
    output cmd_decode_pkg::cmd_pins_t pins
);
    import cmd_decode_pkg::*;

    // ---------------------------------------------------------------
    // Command driving
    // ---------------------------------------------------------------
    int since_exit = 0;

    initial pins = {1'b0, 4'hF, 3'h0, 16'h0};

    // Holds one pin set for one cycle
    task automatic drive(input logic cke, input logic [3:0] ctl,
                         input logic [2:0] ba, input logic [15:0] a);
        @(posedge ref_clk);
        #1;
        pins = {cke, ctl, ba, a};
    endtask

    task automatic issue(input logic cke, input logic [3:0] ctl,
                         input logic [2:0] ba, input logic [15:0] a);
        drive(cke, ctl, ba, a);
        drive(cke, 4'h7, ~ba, ~a);
    endtask

    // counts clocks since clock enable last sat low
    always @(posedge ref_clk)
    begin
        if (pins.cke !== 1'b1)
            since_exit <= 0;
        else if (since_exit < 1000)
            since_exit <= since_exit + 1;
    end

    // write held off for 512 clocks after exit
    task automatic wr_cmd(input logic [2:0] ba, input logic [15:0] a);
        while (since_exit < 512)
            @(posedge ref_clk);
        issue(1'b1, 4'h4, ba, a);
    endtask
endmodule

// ==== dv/tb_cmd_decoder.sv ====
// Self-checking bench for the command decoder, one task per scenario.
// Assumes the controller model drives all pins; reset is synchronous.
`timescale 1ns/1ps
module tb_cmd_decoder;
    import cmd_decode_pkg::*;

    // ---------------------------------------------------------------
    // Harness
    // ---------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic termination_control = 1'b0;
    logic otf = 1'b1;
    logic fc4 = 1'b0;
    logic [4:0] rbits = 5'h0D;
    cmd_pins_t pins;
    cmd_out_t cmd;
    logic [7:0] bank_open;
    logic read_busy, write_busy, in_powerdown, in_self_refresh;
    logic termination_enable, refresh_pulse;
    int n_fail = 0;
    int n_compared = 0;
    int rb, wb, rp, pdc;

    always #2.5 ref_clk = ~ref_clk;

    dram_ctrl_model dram_ctrl_model_i (.ref_clk(ref_clk), .pins(pins));

    cmd_decoder cmd_decoder_i (
        .ref_clk(ref_clk), .rst(rst), .pins(pins),
        .termination_control(termination_control), .burst_on_the_fly(otf),
        .fixed_chop4(fc4), .row_bits(rbits), .col_bits(COL_BITS_RESET), .cmd(cmd),
        .bank_open(bank_open), .read_busy(read_busy), .write_busy(write_busy),
        .in_powerdown(in_powerdown), .in_self_refresh(in_self_refresh),
        .termination_enable(termination_enable), .refresh_pulse(refresh_pulse)
    );

    // Cycle counters for bursts, refresh pulses and power-down
    always @(posedge ref_clk)
    begin
        rb += (read_busy === 1'b1);
        wb += (write_busy === 1'b1);
        rp += (refresh_pulse === 1'b1);
        pdc += (in_powerdown === 1'b1);
    end

    task automatic clr();
        rb = 0;
        wb = 0;
        rp = 0;
        pdc = 0;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Issue a command and stop where its decoded strobe stands
    task automatic go(input logic cke, input logic [3:0] ctl,
                      input logic [2:0] ba, input logic [15:0] a);
        dram_ctrl_model_i.issue(cke, ctl, ba, a);
        wait_n(1);
    endtask

    task automatic ck_cmd(input string w, input cmd_code_t c);
        check(w, {cmd.valid, cmd.code}, {1'b1, c});
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_mode_write();
        for (int s = 0; s < 4; s++)
        begin
            go(1'b1, 4'h0, s[2:0], 16'h0100 + 16'(s));
            ck_cmd("mode write", CMD_MODE_REGISTER_WRITE);
            check("mode sel", cmd.mode_reg_sel, s);
            check("mode data", cmd.mode_data, 16'h0100 + s);
        end
        clr();
        go(1'b1, 4'h1, 3'h0, 16'h0);
        ck_cmd("refresh", CMD_REFRESH);
        wait_n(3);
        check("refresh pulses", rp, 1);
        $display("test mode_refresh done");
    endtask

    task automatic t_read();
        go(1'b1, 4'h3, 3'h5, 16'hFFFF);
        ck_cmd("row open", CMD_ROW_OPEN);
        check("row", cmd.row, 16'h1FFF);
        check("bank", cmd.bank, 3'h5);
        rbits = ROW_BITS_RESET;
        go(1'b1, 4'h3, 3'h5, 16'hFFFF);
        check("row full", cmd.row, 16'hFFFF);
        wait_n(1);
        check("open", bank_open, 8'h20);
        for (int i = 0; i < 2; i++)
        begin
            clr();
            go(1'b1, 4'h5, 3'h5, i ? 16'hFBFF : 16'hEBFF);
            ck_cmd("read", CMD_READ);
            check("chop", cmd.chop4, i == 0);
            check("col", cmd.col, 16'h03FF);
            wait_n(6);
            check("read beats", rb, i ? 4 : 2);
        end
        go(1'b1, 4'h5, 3'h5, 16'h1400);
        check("auto close", cmd.auto_close, 1'b1);
        wait_n(6);
        check("closed", bank_open, 8'h00);
        $display("test read done");
    endtask

    task automatic t_fixed();
        otf = 1'b0;
        for (int j = 0; j < 2; j++)
        begin
            fc4 = j[0];
            clr();
            dram_ctrl_model_i.wr_cmd(3'h1, j ? 16'h1400 : 16'h0000);
            wait_n(1);
            ck_cmd("write", CMD_WRITE);
            check("fixed chop", cmd.chop4, j);
            check("fixed close", cmd.auto_close, j);
            wait_n(6);
            check("write beats", wb, j ? 2 : 4);
        end
        otf = 1'b1;
        $display("test fixed done");
    endtask

    task automatic t_no_cut();
        clr();
        dram_ctrl_model_i.issue(1'b1, 4'h5, 3'h2, 16'h1000);
        dram_ctrl_model_i.issue(1'b1, 4'h5, 3'h2, 16'h1000);
        wait_n(8);
        check("second read", rb, 4);
        clr();
        dram_ctrl_model_i.drive(1'b1, 4'h5, 3'h2, 16'h1000);
        dram_ctrl_model_i.drive(1'b0, 4'h7, 3'h0, 16'h0);
        dram_ctrl_model_i.drive(1'b0, 4'h7, 3'h7, 16'hFFFF);
        dram_ctrl_model_i.drive(1'b1, 4'h7, 3'h0, 16'h0);
        dram_ctrl_model_i.drive(1'b1, 4'h8, 3'h7, 16'hFFFF);
        dram_ctrl_model_i.drive(1'b1, 4'h7, 3'h0, 16'h0);
        wait_n(6);
        check("burst kept", rb, 4);
        check("pd cycles", pdc, 2);
        $display("test no_cut done");
    endtask

    task automatic t_close();
        go(1'b1, 4'h2, 3'h0, 16'h0400);
        go(1'b1, 4'h3, 3'h5, 16'h0);
        go(1'b1, 4'h3, 3'h2, 16'h0);
        wait_n(1);
        check("two open", bank_open, 8'h24);
        go(1'b1, 4'h2, 3'h5, 16'h0);
        ck_cmd("bank close", CMD_BANK_CLOSE);
        wait_n(1);
        check("one open", bank_open, 8'h04);
        go(1'b1, 4'h2, 3'h5, 16'h0400);
        ck_cmd("all close", CMD_ALL_BANK_CLOSE);
        wait_n(1);
        check("none open", bank_open, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            go(1'b1, 4'h6, 3'h0, k ? 16'h0400 : 16'h0);
            ck_cmd("calib", k ? CMD_IMPEDANCE_CAL_LONG : CMD_IMPEDANCE_CAL_SHORT);
        end
        $display("test close_calib done");
    endtask

    task automatic t_idle();
        for (int c = 0; c < 9; c++)
        begin
            termination_control = c[0];
            go(1'b1, c < 8 ? {1'b1, c[2:0]} : 4'h7, 3'h7, 16'hFFFF);
            check("no valid", cmd.valid, 1'b0);
            check("term", termination_enable, c[0]);
        end
        go(1'b0, 4'h7, 3'h0, 16'h0);
        wait_n(1);
        check("in pd", in_powerdown, 1'b1);
        clr();
        for (int r = 0; r < 3; r++)
            dram_ctrl_model_i.issue(1'b0, 4'h1, 3'h0, 16'h0);
        wait_n(2);
        check("pd refresh", rp, 0);
        go(1'b1, 4'h7, 3'h0, 16'h0);
        wait_n(1);
        check("pd exit", in_powerdown, 1'b0);
        $display("test idle_powerdown done");
    endtask

    task automatic t_self_refresh();
        go(1'b1, 4'h2, 3'h0, 16'h0400);
        termination_control = 1'b1;
        go(1'b0, 4'h1, 3'h0, 16'h0);
        ck_cmd("sr entry", CMD_SELF_REFRESH_ENTRY);
        wait_n(1);
        check("in sr", in_self_refresh, 1'b1);
        check("term off", termination_enable, 1'b0);
        go(1'b1, 4'h7, 3'h0, 16'h0);
        wait_n(1);
        check("sr exit", in_self_refresh, 1'b0);
        dram_ctrl_model_i.wr_cmd(3'h3, 16'h0);
        wait_n(1);
        ck_cmd("write after sr", CMD_WRITE);
        $display("test self_refresh done");
    endtask

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Reset, settle clock enable, run every scenario
    initial
    begin
        repeat (5) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        dram_ctrl_model_i.issue(1'b1, 4'h7, 3'h0, 16'h0);
        t_mode_write();
        t_read();
        t_fixed();
        t_no_cut();
        t_close();
        t_idle();
        t_self_refresh();
        stop_test();
    end

    // Watchdog well past the expected run
    initial
    begin
        #100000;
        n_fail++;
        stop_test();
    end
endmodule
